// ===== hw/moctb_timer_base.sv
// Time base, sync/trigger and output compare logic of the timer module.
// Assumes control fields are held stable by software while in use.
`default_nettype none
module moctb_timer_base #(
	parameter bit MULTI_OUTPUT = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire moctb_pkg::moctb_ctl_low_t controlOneLow,
	input wire moctb_pkg::moctb_ctl_high_t controlOneHigh,
	input wire logic [15:0] periodLow,
	input wire logic [15:0] periodHigh,
	input wire logic [31:0] compareA,
	input wire logic [31:0] compareB,
	input wire logic [7:0] timeBaseClocks,
	input wire logic [31:0] syncSources,
	input wire logic startedStatusClear,
	output logic [15:0] counterLow,
	output logic [15:0] counterHigh,
	output logic startedStatus,
	output logic compareEventFlag,
	output logic syncOut,
	output logic compareOut,
	output moctb_pkg::moctb_mode_t activeMode
);
	logic [7:0] clkMeta_r;
	logic [7:0] clkSync_r;
	logic [7:0] clkPrev_r;
	logic [15:0] cntLow_r;
	logic [15:0] cntHigh_r;
	logic started_r;
	logic evtFlag_r;
	logic syncOut_r;
	logic cmpOut_r;
	logic [31:0] bufA_r;
	logic [31:0] bufB_r;
	moctb_pkg::moctb_mode_t mode;
	logic [2:0] clkSrc;
	logic [3:0] fnCode;
	logic wide;
	logic start_on_event_enable;
	logic tick;
	logic evt;
	logic cntClear;
	logic running;
	logic [15:0] perLowEff;
	logic [31:0] fullCount;
	logic [31:0] fullPeriod;
	logic lowWrap;
	logic highWrap;
	logic wideWrap;
	logic periodWrap;
	logic [31:0] cmpAEff;
	logic [31:0] cmpBEff;
	logic [31:0] timerValue;
	logic matchA;
	logic matchB;

	assign clkSrc = controlOneLow.timeBaseSourceSelect;
	assign fnCode = controlOneLow.functionCode;
	assign wide = controlOneLow.wideCountEnable;
	assign start_on_event_enable = controlOneHigh.startOnEventEnable;

	// Decode of the one active function; illegal combinations stop the block
	always_comb begin
		mode = moctb_pkg::MODE_OFF;
		if (controlOneLow.captureFunctionSelect) begin
			mode = moctb_pkg::MODE_CAPTURE;
		end else if (fnCode == moctb_pkg::FN_TIMER) begin
			mode = moctb_pkg::MODE_TIMER;
		end else begin
			unique case (fnCode)
				moctb_pkg::FN_HIGH, moctb_pkg::FN_LOW,
				moctb_pkg::FN_TOGGLE: begin
					mode = moctb_pkg::MODE_COMPARE;
				end
				moctb_pkg::FN_DUAL, moctb_pkg::FN_PWM,
				moctb_pkg::FN_VARFREQ, moctb_pkg::FN_EXTSRC: begin
					if (!wide) begin
						mode = moctb_pkg::MODE_COMPARE;
					end
				end
				moctb_pkg::FN_CENTER: begin
					if (!wide && MULTI_OUTPUT) begin
						mode = moctb_pkg::MODE_COMPARE;
					end
				end
				default: begin
					mode = moctb_pkg::MODE_OFF;
				end
			endcase
		end
	end

	// Two-stage synchroniser for the timeBaseClocks sources, then edge detect; the system clock source bypasses it
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			clkMeta_r <= 8'h00;
			clkSync_r <= 8'h00;
			clkPrev_r <= 8'h00;
		end else begin
			clkMeta_r <= timeBaseClocks;
			clkSync_r <= clkMeta_r;
			clkPrev_r <= clkSync_r;
		end
	end

	always_comb begin
		if (clkSrc == moctb_pkg::CLK_SYSTEM) begin
			tick = 1'b1;
		end else begin
			tick = clkSync_r[clkSrc] & ~clkPrev_r[clkSrc];
		end
	end

	// Source 00000 means free running with no sync input
	assign evt = (controlOneHigh.sourceSelect != moctb_pkg::SRC_NONE) &&
		syncSources[controlOneHigh.sourceSelect];

	// Started status: a trigger in the clear cycle wins
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			started_r <= 1'b0;
		end else if (!start_on_event_enable) begin
			started_r <= 1'b0;
		end else if (evt) begin
			started_r <= 1'b1;
		end else if (startedStatusClear) begin
			started_r <= 1'b0;
		end
	end

	assign cntClear = start_on_event_enable ? (!started_r || startedStatusClear)
		: evt;
	assign running = (mode != moctb_pkg::MODE_OFF) && !cntClear && tick;

	// Variable frequency mode takes its period from compare A
	assign perLowEff = (mode == moctb_pkg::MODE_COMPARE &&
		fnCode == moctb_pkg::FN_VARFREQ) ? compareA[15:0] : periodLow;
	assign fullCount = {cntHigh_r, cntLow_r};
	assign fullPeriod = {periodHigh, perLowEff};
	assign lowWrap = cntLow_r == perLowEff;
	assign highWrap = cntHigh_r == periodHigh;
	assign wideWrap = fullCount == fullPeriod;
	assign periodWrap = running && (wide ? wideWrap : lowWrap);

	// Counter pair: two 16-bit timers or one 32-bit timer
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			cntLow_r <= moctb_pkg::CNT_RESET;
			cntHigh_r <= moctb_pkg::CNT_RESET;
		end else if (mode == moctb_pkg::MODE_OFF || cntClear) begin
			cntLow_r <= moctb_pkg::CNT_RESET;
			cntHigh_r <= moctb_pkg::CNT_RESET;
		end else if (tick) begin
			if (wide) begin
				if (wideWrap) begin
					cntLow_r <= moctb_pkg::CNT_RESET;
					cntHigh_r <= moctb_pkg::CNT_RESET;
				end else begin
					cntLow_r <= cntLow_r + 16'h0001;
					if (cntLow_r == moctb_pkg::CNT_LOW_MAX) begin
						cntHigh_r <= cntHigh_r + 16'h0001;
					end
				end
			end else begin
				cntLow_r <= lowWrap ? moctb_pkg::CNT_RESET
					: cntLow_r + 16'h0001;
				cntHigh_r <= highWrap ? moctb_pkg::CNT_RESET
					: cntHigh_r + 16'h0001;
			end
		end
	end

	// Compare values, buffered ones reload at each period rollover
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			bufA_r <= 32'h00000000;
			bufB_r <= 32'h00000000;
		end else if (periodWrap || mode != moctb_pkg::MODE_COMPARE) begin
			bufA_r <= compareA;
			bufB_r <= compareB;
		end
	end

	always_comb begin
		cmpAEff = compareA;
		cmpBEff = compareB;
		if (fnCode == moctb_pkg::FN_PWM || fnCode == moctb_pkg::FN_CENTER) begin
			cmpAEff = bufA_r;
			cmpBEff = bufB_r;
		end
		if (!wide) begin
			cmpAEff = {16'h0000, cmpAEff[15:0]};
			cmpBEff = {16'h0000, cmpBEff[15:0]};
		end
	end

	assign timerValue = wide ? fullCount : {16'h0000, cntLow_r};
	assign matchA = running && timerValue == cmpAEff;
	assign matchB = running && timerValue == cmpBEff;

	// Sync output and compare event flag, one-cycle pulses
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			syncOut_r <= 1'b0;
			evtFlag_r <= 1'b0;
		end else begin
			syncOut_r <= periodWrap && mode != moctb_pkg::MODE_CAPTURE;
			unique case (mode)
				moctb_pkg::MODE_TIMER: begin
					evtFlag_r <= running && (wide ? wideWrap : highWrap);
				end
				moctb_pkg::MODE_COMPARE: begin
					evtFlag_r <= matchA || matchB;
				end
				moctb_pkg::MODE_CAPTURE, moctb_pkg::MODE_OFF: begin
					evtFlag_r <= 1'b0;
				end
			endcase
		end
	end

	// Compare output pin level
	always_ff @(posedge sys_clk) begin
		if (!rst_n || mode != moctb_pkg::MODE_COMPARE) begin
			cmpOut_r <= 1'b0;
		end else begin
			unique case (fnCode)
				moctb_pkg::FN_HIGH: if (matchA) cmpOut_r <= 1'b1;
				moctb_pkg::FN_LOW: if (matchA) cmpOut_r <= 1'b0;
				moctb_pkg::FN_TOGGLE: if (matchA) cmpOut_r <= !cmpOut_r;
				moctb_pkg::FN_DUAL, moctb_pkg::FN_PWM,
				moctb_pkg::FN_CENTER: begin
					if (matchA) begin
						cmpOut_r <= 1'b1;
					end else if (matchB) begin
						cmpOut_r <= 1'b0;
					end
				end
				moctb_pkg::FN_VARFREQ: if (periodWrap) cmpOut_r <= !cmpOut_r;
				moctb_pkg::FN_EXTSRC: cmpOut_r <= evt;
				default: cmpOut_r <= 1'b0;
			endcase
		end
	end

	assign counterLow = cntLow_r;
	assign counterHigh = cntHigh_r;
	assign startedStatus = started_r;
	assign compareEventFlag = evtFlag_r;
	assign syncOut = syncOut_r;
	assign compareOut = cmpOut_r;
	assign activeMode = mode;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	a_sys_clk_step: assert property (
		mode == moctb_pkg::MODE_TIMER && clkSrc == moctb_pkg::CLK_SYSTEM &&
		!wide && !cntClear && !lowWrap
		|=> cntLow_r == $past(cntLow_r) + 16'h0001)
		else $error("low counter did not step on system clock");
	a_sync_clears: assert property (
		!start_on_event_enable && evt && mode != moctb_pkg::MODE_OFF
		|=> cntLow_r == 16'h0000 && cntHigh_r == 16'h0000)
		else $error("sync event did not clear the timer");
	a_trig_hold: assert property (
		(start_on_event_enable && !started_r && !evt) [*3] |-> cntLow_r == 16'h0000)
		else $error("timer ran before its trigger");
	a_trig_start: assert property (
		start_on_event_enable && evt |=> started_r)
		else $error("trigger did not set started status");
	a_clear_holds: assert property (
		start_on_event_enable && started_r && startedStatusClear && !evt
		|=> !started_r && cntLow_r == 16'h0000)
		else $error("started clear did not stop the timer");
	a_wide_carry: assert property (
		wide && mode == moctb_pkg::MODE_TIMER && running && !wideWrap &&
		cntLow_r == 16'hFFFF
		|=> cntLow_r == 16'h0000 && cntHigh_r == $past(cntHigh_r) + 16'h0001)
		else $error("low overflow did not carry into high counter");
	a_dual_flag: assert property (
		!wide && mode == moctb_pkg::MODE_TIMER && running && highWrap
		|=> compareEventFlag ##1 (cntHigh_r != 16'h0000 || !compareEventFlag ||
		$past(running && highWrap)))
		else $error("high period match did not raise the event flag");
	a_sync_low_only: assert property (
		!wide && mode == moctb_pkg::MODE_TIMER && syncOut
		|-> $past(running && lowWrap))
		else $error("sync output not caused by the low timer");
	a_wide_illegal: assert property (
		!controlOneLow.captureFunctionSelect && wide &&
		fnCode >= moctb_pkg::FN_DUAL && fnCode <= moctb_pkg::FN_VARFREQ
		|-> activeMode == moctb_pkg::MODE_OFF ##1 !compareOut)
		else $error("16-bit only code ran in wide mode");
	a_out_high: assert property (
		mode == moctb_pkg::MODE_COMPARE && fnCode == moctb_pkg::FN_HIGH &&
		matchA ##1 mode == moctb_pkg::MODE_COMPARE |-> compareOut)
		else $error("output did not go high on compare match");

	c_wide_carry: cover property (wide && running && cntLow_r == 16'hFFFF);
	c_trig_cycle: cover property (start_on_event_enable && evt ##[1:20] startedStatusClear);
	c_pwm_pulse: cover property (fnCode == moctb_pkg::FN_PWM && compareOut
		##[1:50] !compareOut);
	c_dual_flag: cover property (!wide && compareEventFlag);
endmodule : moctb_timer_base
`default_nettype wire

// ===== hw/moctb_pkg.sv
// Package for the compare/PWM timer base: control layouts, codes, modes.
// Assumes every input except timeBaseClocks is synchronous to sys_clk.
`default_nettype none
package moctb_pkg;
	// Field positions of control_one_low, control_one_high and status_low
	localparam int CTL1L_CLKSEL_LSB = 8;
	localparam int CTL1L_WIDE_BIT = 5;
	localparam int CTL1L_CAPSEL_BIT = 4;
	localparam int CTL1H_START_ON_EVENT_ENABLE_BIT = 7;
	localparam int CTL1H_SRCSEL_LSB = 0;
	localparam int STAT_STARTED_BIT = 7;
	localparam int STAT_CLEAR_BIT = 5;

	typedef struct packed {
		logic [4:0] unusedHigh;
		logic [2:0] timeBaseSourceSelect;
		logic [1:0] unusedMid;
		logic wideCountEnable;
		logic captureFunctionSelect;
		logic [3:0] functionCode;
	} moctb_ctl_low_t;

	typedef struct packed {
		logic [7:0] unusedHigh;
		logic startOnEventEnable;
		logic [1:0] unusedMid;
		logic [4:0] sourceSelect;
	} moctb_ctl_high_t;

	typedef enum logic [1:0] {
		MODE_TIMER = 2'b00,
		MODE_CAPTURE = 2'b01,
		MODE_COMPARE = 2'b10,
		MODE_OFF = 2'b11
	} moctb_mode_t;

	localparam logic [2:0] CLK_SYSTEM = 3'h0;
	localparam logic [4:0] SRC_NONE = 5'h00;
	localparam logic [3:0] FN_TIMER = 4'h0;
	localparam logic [3:0] FN_HIGH = 4'h1;
	localparam logic [3:0] FN_LOW = 4'h2;
	localparam logic [3:0] FN_TOGGLE = 4'h3;
	localparam logic [3:0] FN_DUAL = 4'h4;
	localparam logic [3:0] FN_PWM = 4'h5;
	localparam logic [3:0] FN_CENTER = 4'h6;
	localparam logic [3:0] FN_VARFREQ = 4'h7;
	localparam logic [3:0] FN_EXTSRC = 4'hF;
	localparam logic [15:0] CNT_RESET = 16'h0000;
	localparam logic [15:0] CNT_LOW_MAX = 16'hFFFF;
endpackage : moctb_pkg
`default_nettype wire

// ===== verif/moctb_far_side.sv
// Far-side model: event sources and an external time base clock.
// Assumes the bench drives its requests at the falling edge.
`default_nettype none
module moctb_far_side (
	input wire logic sys_clk,
	input wire logic [4:0] eventSel,
	input wire logic eventFire,
	input wire logic extClkRun,
	output logic [7:0] timeBaseClocks,
	output logic [31:0] syncSources
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] divCnt;
	initial begin
		divCnt = 2'h0;
		timeBaseClocks = 8'h00;
	end
	// Source 31 is never fired as a sync event
	assign syncSources = eventFire ?
		(32'h00000001 << eventSel) & 32'h7FFFFFFF : 32'h00000000;
	// External clock, eight cycles a period, still when not running
	always @(negedge sys_clk) begin
		if (extClkRun) begin
			divCnt <= divCnt + 2'h1;
			if (divCnt == 2'h3) begin
				timeBaseClocks[3] <= ~timeBaseClocks[3];
			end
		end
	end
endmodule : moctb_far_side
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the compare/PWM timer base.
// Assumes the far-side model supplies clock sources and events.
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b0;
	logic rst_n;
	moctb_pkg::moctb_ctl_low_t cl;
	moctb_pkg::moctb_ctl_high_t ch;
	logic [15:0] periodLow, periodHigh, counterLow, counterHigh;
	logic [31:0] compareA, compareB, syncSources, seed;
	logic [7:0] timeBaseClocks;
	logic startedStatusClear, startedStatus, compareEventFlag, syncOut;
	logic compareOut, eventFire, extClkRun;
	logic [4:0] eventSel;
	moctb_pkg::moctb_mode_t activeMode, modeSingle;
	int fails = 0, check_count = 0, cyc = 0, n, g;

	moctb_far_side far (.sys_clk, .eventSel, .eventFire, .extClkRun,
		.timeBaseClocks, .syncSources);
	moctb_timer_base dut (.sys_clk, .rst_n, .controlOneLow(cl),
		.controlOneHigh(ch), .periodLow, .periodHigh, .compareA, .compareB,
		.timeBaseClocks, .syncSources, .startedStatusClear, .counterLow,
		.counterHigh, .startedStatus, .compareEventFlag, .syncOut,
		.compareOut, .activeMode);
	moctb_timer_base #(.MULTI_OUTPUT(1'b0)) dutSingle (.sys_clk, .rst_n,
		.controlOneLow(cl), .controlOneHigh(ch), .periodLow, .periodHigh,
		.compareA, .compareB, .timeBaseClocks, .syncSources,
		.startedStatusClear, .counterLow(), .counterHigh(), .startedStatus(),
		.compareEventFlag(), .syncOut(), .compareOut(),
		.activeMode(modeSingle));

	always #20 sys_clk = ~sys_clk;

	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 70000) begin
			fails++;
			close_out();
		end
	end

	task automatic close_out();
		if (fails == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : close_out

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tick(input int k);
		repeat (k) @(negedge sys_clk);
	endtask : tick

	// Leaves source 0 firing; the design must ignore it
	task automatic restart(input logic [4:0] sel);
		ch.sourceSelect = sel;
		eventSel = sel;
		eventFire = 1'b1;
		tick(1);
		ch.sourceSelect = 5'h00;
		eventSel = 5'h00;
	endtask : restart

	task automatic run_count(input logic [31:0] per, input int len,
		input logic wide);
		logic [31:0] q, r;
		q = 32'h00000000;
		r = 32'h00000000;
		for (int i = 0; i < len; i++) begin
			chk(wide ? {counterHigh, counterLow} : {16'h0000, counterLow},
				q);
			if (i > 0) chk(32'(syncOut), 32'(r == per));
			r = q;
			q = (q == per) ? 32'h00000000 : q + 32'h00000001;
			tick(1);
		end
	endtask : run_count

	function automatic moctb_pkg::moctb_mode_t mode_of(input logic cap,
		input logic wide, input logic [3:0] code, input logic multi);
		if (cap) return moctb_pkg::MODE_CAPTURE;
		if (code == 4'h0) return moctb_pkg::MODE_TIMER;
		if (code <= 4'h3) return moctb_pkg::MODE_COMPARE;
		if (wide || code inside {[4'h8:4'hE]}) return moctb_pkg::MODE_OFF;
		if (code == 4'h6 && !multi) return moctb_pkg::MODE_OFF;
		return moctb_pkg::MODE_COMPARE;
	endfunction : mode_of

	initial begin
		seed = 32'hC2B030DC;
		rst_n = 1'b0;
		cl = 16'h0001;
		ch = 16'h0000;
		periodLow = 16'h0014;
		periodHigh = 16'hFFFF;
		compareA = 32'h00000005;
		compareB = 32'h00000064;
		startedStatusClear = 1'b0;
		eventSel = 5'h00;
		eventFire = 1'b0;
		extClkRun = 1'b0;
		tick(3);
		rst_n = 1'b1;
		// Output high, low, toggle on compare match
		for (int k = 1; k < 4; k++) begin
			cl.functionCode = 4'(k);
			restart(5'h04);
			n = 0;
			for (int i = 0; i < 12; i++) begin
				if (i == 3) chk(32'(compareOut), 32'(k == 2));
				n += int'(compareEventFlag);
				tick(1);
			end
			chk(32'(compareOut), 32'(k != 2));
			chk(n, 1);
		end
		cl = 16'h0000;
		repeat (4) begin
			periodLow = 16'(2 + {$random(seed)} % 8);
			restart(5'(1 + {$random(seed)} % 30));
			run_count({16'h0000, periodLow}, 3 * periodLow + 3, 1'b0);
		end
		periodLow = 16'hFFFF;
		periodHigh = 16'(2 + {$random(seed)} % 8);
		restart(5'h01);
		n = 0;
		g = 0;
		for (int i = 0; i <= 3 * (periodHigh + 1); i++) begin
			chk(32'(syncOut), 32'h00000000);
			if (compareEventFlag === 1'b1) begin
				chk(32'(counterHigh), 32'h00000000);
				if (n > 0) chk(g, periodHigh + 1);
				n++;
				g = 0;
			end
			g++;
			tick(1);
		end
		chk(n, 3);
		cl.timeBaseSourceSelect = 3'h3;
		extClkRun = 1'b1;
		restart(5'h02);
		tick(16);
		g = counterLow;
		tick(80);
		chk(counterLow - g, 10);
		extClkRun = 1'b0;
		cl = 16'h0020;
		tick(1);
		periodHigh = 16'h0001;
		periodLow = 16'h0002;
		ch = 16'h0080;
		tick(4);
		chk({counterHigh, counterLow}, 32'h00000000);
		chk(32'(startedStatus), 32'h00000000);
		restart(5'h1E);
		chk(32'(startedStatus), 32'h00000001);
		run_count(32'h00010002, 65542, 1'b1);
		chk(32'(startedStatus), 32'h00000001);
		startedStatusClear = 1'b1;
		tick(1);
		startedStatusClear = 1'b0;
		chk(32'(startedStatus), 32'h00000000);
		chk({counterHigh, counterLow}, 32'h00000000);
		tick(3);
		chk({counterHigh, counterLow}, 32'h00000000);
		ch = 16'h0000;
		eventFire = 1'b0;
		// Dual edge, plain then buffered: high at A, low at B
		compareA = 32'h00000003;
		compareB = 32'h00000006;
		periodLow = 16'h0009;
		for (int k = 4; k < 6; k++) begin
			cl = 16'h0000;
			tick(1);
			cl = 16'(k);
			restart(5'h05);
			tick(5);
			chk(32'(compareOut), 32'h00000001);
			tick(3);
			chk(32'(compareOut), 32'h00000000);
		end
		eventFire = 1'b0;
		// Every function code, both widths, both variants
		for (int w = 0; w < 2; w++) begin
			for (int c = 0; c < 22; c++) begin
				cl = {5'h00, 3'h0, 2'h0, w[0], c > 15, 4'(c)};
				tick(1);
				chk(32'(activeMode),
					32'(mode_of(c > 15, w[0], 4'(c), 1'b1)));
				chk(32'(modeSingle),
					32'(mode_of(c > 15, w[0], 4'(c), 1'b0)));
			end
		end
		close_out();
	end
endmodule : tb_top
`default_nettype wire
